// ---- core/indicator_pkg.sv ----
// package for the light curtain status indicator block
// assumes a single 10 MHz system clock and a classic wishbone register bus
package indicator_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int FAST_HALF_NS = 50_000_000;
    localparam int FAST_HALF_CYCLES = FAST_HALF_NS / CLK_PERIOD_NS;
    localparam logic [4:0] PHASE_STEPS = 5'h14;
    localparam logic [4:0] SLOW_HALF_STEPS = 5'h0a;
    localparam logic [4:0] PHASE_LAST = 5'h13;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int IRQ_BITS = 5;
    localparam int IRQ_INTERNAL_FAULT = 0;
    localparam int IRQ_EXTERNAL_FAULT = 1;
    localparam int IRQ_CHANNEL_CHANGE = 2;
    localparam int IRQ_TEACH_ERROR = 3;
    localparam int IRQ_CHANGEOVER = 4;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic safetyOutputA;
        logic safetyOutputB;
        logic weakSignal;
        logic internalFault;
        logic externalFault;
        logic restartInterlockEnabled;
        logic restartInterlockLocked;
        logic fieldClear;
        logic linkedEnable;
        logic upstreamOpen;
        logic upstreamChangeover;
        logic changeoverTwice;
        logic blankingTaught;
        logic mutingActive;
        logic teaching;
        logic mutingRestartReq;
        logic mutingOverride;
        logic teachError;
    } rx_state_type;

    typedef struct packed {
        logic red1;
        logic green1;
        logic yellow2;
        logic blue3;
    } lamp_type;

endpackage

// ---- core/status_indicator.sv ----
// status indicator logic of a safety light curtain receiver
// assumes receiver state inputs synchronous to clk_sys, classic wishbone master
// Behaviour
// - line a high and b low picks channel one; swapped picks channel two
// - lamp one steady red when safety outputs off and no fault pending
// - lamp one red flashes 1 Hz on external fault, 10 Hz on internal
// - lamp one green flashes 1 Hz when outputs on but signal weak
// - lamp one steady green when outputs on and signal adequate
// - lamp two dark unless interlock locked and releasable or upstream events
// - lamp two steady yellow when interlock locked but releasable
// - lamp two flashes yellow while upstream safety circuit is open
// - lamp two gives one or two yellow flashes on upstream changeover
// - lamp three dark while no special function is active
// - lamp three steady blue once blanking parameters are taught
// - lamp three flashes blue at 1 Hz while muting is active
// - lamp three short blue flashes on teaching, muting restart or override
// - lamp three flashes blue at 10 Hz on a teach error
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module status_indicator #(
    parameter int FAST_HALF_CYCLES = indicator_pkg::FAST_HALF_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // receiver state and supply lines
    input wire indicator_pkg::rx_state_type rxState,
    input wire logic supplyLineA,
    input wire logic supplyLineB,
    // indicator lamps, channel and interrupt
    output indicator_pkg::lamp_type lamps,
    output logic channelTwo,
    output logic supplyInvalid,
    output logic irq
);

    // ****************************************************************
    // flash timebase
    // ****************************************************************
    // one 50 ms step counter feeds every pattern so all lamps flash in phase
    logic [31:0] prescale;
    logic [4:0] phase;
    wire stepTick = (prescale == 32'(FAST_HALF_CYCLES - 1));
    wire phaseWrap = stepTick && (phase == indicator_pkg::PHASE_LAST);
    wire slowOn = (phase < indicator_pkg::SLOW_HALF_STEPS);
    wire fastOn = ~phase[0];
    wire shortOn = (phase == 5'h00);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prescale <= 32'h0000_0000;
            phase <= 5'h00;
        end else begin
            prescale <= stepTick ? 32'h0000_0000 : prescale + 32'h0000_0001;
            if (stepTick) begin
                phase <= phaseWrap ? 5'h00 : phase + 5'h01;
            end
        end
    end

    // ****************************************************************
    // registers and bus decode
    // ****************************************************************
    logic [31:0] ctrl;
    logic [4:0] irqStatus;
    logic [4:0] irqMask;
    logic busy;
    wire request = cyc_i && stb_i && !ack_o;
    wire writeLow = request && we_i && sel_i[0];
    wire hitCtrl = (adr_i == indicator_pkg::CTRL_OFFSET);
    wire hitStatus = (adr_i == indicator_pkg::STATUS_OFFSET);
    wire hitIrqStatus = (adr_i == indicator_pkg::IRQ_STATUS_OFFSET);
    wire hitIrqMask = (adr_i == indicator_pkg::IRQ_MASK_OFFSET);
    wire enable = ctrl[indicator_pkg::CTRL_ENABLE_BIT];
    wire [31:0] statusWord = {24'h000000, supplyInvalid, channelTwo, busy, 1'b0, lamps};
    wire [31:0] readWord = hitCtrl ? ctrl :
                           hitStatus ? statusWord :
                           hitIrqStatus ? {27'h0000000, irqStatus} :
                           hitIrqMask ? {27'h0000000, irqMask} : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            ctrl <= indicator_pkg::CTRL_RESET;
            irqMask <= indicator_pkg::IRQ_MASK_RESET;
        end else begin
            ack_o <= request;
            dat_o <= request ? readWord : 32'h0000_0000;
            if (writeLow && hitCtrl) begin
                ctrl <= {31'h00000000, dat_i[indicator_pkg::CTRL_ENABLE_BIT]};
            end
            if (writeLow && hitIrqMask) begin
                irqMask <= dat_i[4:0];
            end
        end
    end

    // ****************************************************************
    // channel selection
    // ****************************************************************
    // an undefined polarity keeps the last channel and is flagged instead
    wire polarityOne = supplyLineA && !supplyLineB;
    wire polarityTwo = !supplyLineA && supplyLineB;
    wire next_channelTwo = polarityTwo ? 1'b1 : (polarityOne ? 1'b0 : channelTwo);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            channelTwo <= 1'b0;
            supplyInvalid <= 1'b0;
        end else begin
            channelTwo <= next_channelTwo;
            supplyInvalid <= !(polarityOne || polarityTwo);
        end
    end

    // ****************************************************************
    // counted changeover flashes
    // ****************************************************************
    // a request waits for the next period start so every flash is a full one
    logic pending;
    logic pendingTwice;
    logic [1:0] flashesLeft;
    wire startBurst = pending && phaseWrap && (flashesLeft == 2'h0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending <= 1'b0;
            pendingTwice <= 1'b0;
            flashesLeft <= 2'h0;
        end else begin
            if (rxState.upstreamChangeover) begin
                pending <= 1'b1;
                pendingTwice <= rxState.changeoverTwice;
            end else if (startBurst) begin
                pending <= 1'b0;
            end
            if (startBurst) begin
                flashesLeft <= pendingTwice ? 2'h2 : 2'h1;
            end else if (phaseWrap && flashesLeft != 2'h0) begin
                flashesLeft <= flashesLeft - 2'h1;
            end
        end
    end
    assign busy = pending || (flashesLeft != 2'h0);

    // ****************************************************************
    // lamp pattern selection
    // ****************************************************************
    wire outputsOn = rxState.safetyOutputA && rxState.safetyOutputB;
    wire interlockReady = rxState.restartInterlockEnabled && rxState.restartInterlockLocked &&
                          rxState.fieldClear && rxState.linkedEnable;
    wire shortCause = rxState.teaching || rxState.mutingRestartReq || rxState.mutingOverride;
    // internal fault outranks external fault, which outranks the output states
    wire next_red1 = rxState.internalFault ? fastOn :
                     rxState.externalFault ? slowOn :
                     !outputsOn;
    wire next_green1 = !rxState.internalFault && !rxState.externalFault && outputsOn &&
                       (rxState.weakSignal ? slowOn : 1'b1);
    wire next_yellow2 = (flashesLeft != 2'h0) ? slowOn :
                        rxState.upstreamOpen ? slowOn :
                        interlockReady;
    wire next_blue3 = rxState.teachError ? fastOn :
                      shortCause ? shortOn :
                      rxState.mutingActive ? slowOn :
                      rxState.blankingTaught;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lamps <= '0;
        end else begin
            lamps.red1 <= enable && next_red1;
            lamps.green1 <= enable && next_green1;
            lamps.yellow2 <= enable && next_yellow2;
            lamps.blue3 <= enable && next_blue3;
        end
    end

    // ****************************************************************
    // interrupts
    // ****************************************************************
    logic lastInternal;
    logic lastExternal;
    logic lastTeachError;
    wire [4:0] events = {rxState.upstreamChangeover,
                         rxState.teachError && !lastTeachError,
                         next_channelTwo != channelTwo,
                         rxState.externalFault && !lastExternal,
                         rxState.internalFault && !lastInternal};
    wire [4:0] clearBits = (writeLow && hitIrqStatus) ? dat_i[4:0] : 5'h00;
    wire [4:0] irqNext = (irqStatus & ~clearBits) | events;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            lastInternal <= 1'b0;
            lastExternal <= 1'b0;
            lastTeachError <= 1'b0;
            irqStatus <= 5'h00;
            irq <= 1'b0;
        end else begin
            lastInternal <= rxState.internalFault;
            lastExternal <= rxState.externalFault;
            lastTeachError <= rxState.teachError;
            // a new event in the clearing cycle survives the clear
            irqStatus <= irqNext;
            irq <= |(irqNext & irqMask);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_channel_one;
        polarityOne |=> !channelTwo;
    endproperty
    a_channel_one: assert property (p_channel_one) else $error("channel one not chosen");

    property p_channel_two;
        polarityTwo |=> channelTwo;
    endproperty
    a_channel_two: assert property (p_channel_two) else $error("channel two not chosen");

    property p_red_steady;
        enable && !outputsOn && !rxState.internalFault && !rxState.externalFault
            |=> lamps.red1 && !lamps.green1;
    endproperty
    a_red_steady: assert property (p_red_steady) else $error("red not steady");

    property p_internal_fast;
        enable && rxState.internalFault |=> lamps.red1 == $past(fastOn) && !lamps.green1;
    endproperty
    a_internal_fast: assert property (p_internal_fast) else $error("internal fault pattern");

    property p_external_slow;
        enable && rxState.externalFault && !rxState.internalFault
            |=> lamps.red1 == $past(slowOn);
    endproperty
    a_external_slow: assert property (p_external_slow) else $error("external fault pattern");

    property p_green;
        enable && outputsOn && !rxState.internalFault && !rxState.externalFault
            |=> lamps.green1 == ($past(rxState.weakSignal) ? $past(slowOn) : 1'b1);
    endproperty
    a_green: assert property (p_green) else $error("green pattern wrong");

    property p_yellow_ready;
        enable && interlockReady && !rxState.upstreamOpen && !busy |=> lamps.yellow2;
    endproperty
    a_yellow_ready: assert property (p_yellow_ready) else $error("yellow not steady");

    property p_yellow_dark;
        enable && !interlockReady && !rxState.upstreamOpen && flashesLeft == 2'h0
            |=> !lamps.yellow2;
    endproperty
    a_yellow_dark: assert property (p_yellow_dark) else $error("yellow not dark");

    property p_blue_dark;
        !rxState.teachError && !shortCause && !rxState.mutingActive && !rxState.blankingTaught
            |=> !lamps.blue3;
    endproperty
    a_blue_dark: assert property (p_blue_dark) else $error("blue not dark");

    property p_blue_teach_error;
        enable && rxState.teachError |=> lamps.blue3 == $past(fastOn);
    endproperty
    a_blue_teach_error: assert property (p_blue_teach_error) else $error("teach error");

    property p_blue_short;
        enable && shortCause && !rxState.teachError |=> lamps.blue3 == $past(shortOn);
    endproperty
    a_blue_short: assert property (p_blue_short) else $error("short flash wrong");

    property p_blue_muting;
        enable && rxState.mutingActive && !shortCause && !rxState.teachError
            |=> lamps.blue3 == $past(slowOn);
    endproperty
    a_blue_muting: assert property (p_blue_muting) else $error("muting pattern wrong");

    property p_phase_wrap;
        phaseWrap |=> phase == 5'h00;
    endproperty
    a_phase_wrap: assert property (p_phase_wrap) else $error("phase did not wrap");

    property p_irq_level;
        ##1 irq == |($past(irqNext) & $past(irqMask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    c_internal: cover property (enable && rxState.internalFault ##1 lamps.red1);
    c_changeover_twice: cover property (startBurst && pendingTwice);
    c_bus_ack: cover property (cyc_i && stb_i ##1 ack_o);
    c_channel_swap: cover property (polarityOne ##1 polarityTwo);

endmodule

// ---- testbench/safety_circuit_model.sv ----
// far side model: safety circuit, linked sensors and operator giving receiver states
// assumes one clock; the bench picks the wanted states and supply polarity
`timescale 1ns/100ps
module safety_circuit_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // wanted states
    input wire indicator_pkg::rx_state_type wantState,
    input wire logic changeReq,
    input wire logic changeTwice,
    input wire logic wantLineA,
    input wire logic wantLineB,
    // to the receiver
    output indicator_pkg::rx_state_type rxState,
    output logic supplyLineA,
    output logic supplyLineB
);
    logic reqSeen;
    indicator_pkg::rx_state_type next_rxState;
    // changeover is one pulse however long the request stays up
    always_comb begin
        next_rxState = wantState;
        next_rxState.upstreamChangeover = changeReq && !reqSeen && !rst;
        next_rxState.changeoverTwice = changeTwice;
    end
    always_ff @(posedge clk_sys) begin
        reqSeen <= changeReq && !rst;
        rxState <= next_rxState;
        supplyLineA <= wantLineA;
        supplyLineB <= wantLineB;
    end
endmodule

// ---- testbench/light_curtain_status_indicator_tb_top.sv ----
// testbench for the status indicator: lamp patterns, channel, registers, interrupt
// assumes FAST_HALF_CYCLES of 4, so a 1 Hz period is 80 clocks and 10 Hz is 8
`timescale 1ns/100ps
module light_curtain_status_indicator_tb_top;
    logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic changeReq = 0, changeTwice = 0, lineA = 1, lineB = 0, chanTwo, badSupply;
    indicator_pkg::rx_state_type s = '0, rxState;
    indicator_pkg::lamp_type lamps;
    logic supA, supB;
    int failures = 0, num_checks = 0, cycles = 0;

    initial forever #50 clk_sys = ~clk_sys;

    safety_circuit_model far (.clk_sys(clk_sys), .rst(rst), .wantState(s),
        .changeReq(changeReq), .changeTwice(changeTwice), .wantLineA(lineA),
        .wantLineB(lineB), .rxState(rxState), .supplyLineA(supA), .supplyLineB(supB));

    status_indicator #(.FAST_HALF_CYCLES(4)) dut (.clk_sys(clk_sys), .rst(rst),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
        .dat_o(rdat), .ack_o(ack), .rxState(rxState), .supplyLineA(supA),
        .supplyLineB(supB), .lamps(lamps), .channelTwo(chanTwo),
        .supplyInvalid(badSupply), .irq(irq));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // a hung run still ends in the one closing report
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 12000) begin
            failures++;
            report_and_stop();
        end
    end

    task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat;
        check(32'(n < 20), 32'h1, "bus answer");
        cyc <= 0;
        stb <= 0;
        @(posedge clk_sys);
    endtask

    // apply state s and let it pass the model and the lamp register
    task automatic go();
        repeat (4) @(posedge clk_sys);
    endtask

    // lamp index 3 red, 2 green, 1 yellow, 0 blue; phase-free: counts over a window
    task automatic pat(int idx, int len, int on, int rises);
        int n1, nr;
        logic p;
        n1 = 0;
        nr = 0;
        p = lamps[idx];
        repeat (len) begin
            @(posedge clk_sys);
            if (lamps[idx] === 1'b1) n1++;
            if (lamps[idx] === 1'b1 && p !== 1'b1) nr++;
            p = lamps[idx];
        end
        check(32'(n1), 32'(on), "lamp on cycles");
        check(32'(nr), 32'(rises), "lamp flashes");
    endtask

    task automatic t_channel();
        lineA <= 1; lineB <= 0; go();
        check(32'({chanTwo, badSupply}), 32'h0, "channel one");
        lineA <= 0; lineB <= 1; go();
        check(32'({chanTwo, badSupply}), 32'h2, "channel two");
        lineA <= 1; go();
        check(32'({chanTwo, badSupply}), 32'h3, "equal lines");
        // status: invalid supply, channel two, no burst, red steady only
        wb(0, indicator_pkg::STATUS_OFFSET, 32'h0, q);
        check(q, 32'h0000_00c8, "status word");
        lineB <= 0; go();
    endtask

    task automatic t_lamp_one();
        s <= '0; go();
        pat(3, 80, 80, 0);
        s.externalFault <= 1; go();
        pat(3, 80, 40, 1);
        s.internalFault <= 1; go();
        pat(3, 80, 40, 10);
        s <= '0; s.safetyOutputA <= 1; s.safetyOutputB <= 1; go();
        pat(2, 80, 80, 0);
        pat(3, 80, 0, 0);
        s.weakSignal <= 1; go();
        pat(2, 80, 40, 1);
        s.internalFault <= 1; go();
        pat(2, 80, 0, 0);
    endtask

    task automatic t_lamp_two();
        s <= '0; s.restartInterlockEnabled <= 1; go();
        pat(1, 80, 0, 0);
        s.restartInterlockLocked <= 1; s.linkedEnable <= 1; go();
        pat(1, 80, 0, 0);
        s.fieldClear <= 1; go();
        pat(1, 80, 80, 0);
        s.upstreamOpen <= 1; go();
        pat(1, 80, 40, 1);
        s <= '0; go();
        changeTwice <= 1; changeReq <= 1;
        pat(1, 260, 80, 2);
        changeReq <= 0; changeTwice <= 0; go();
        changeReq <= 1;
        pat(1, 260, 40, 1);
        changeReq <= 0;
    endtask

    task automatic t_lamp_three();
        s <= '0; go();
        pat(0, 80, 0, 0);
        s.blankingTaught <= 1; go();
        pat(0, 80, 80, 0);
        s.mutingActive <= 1; go();
        pat(0, 80, 40, 1);
        s.teaching <= 1; go();
        pat(0, 80, 4, 1);
        s.teaching <= 0; s.mutingRestartReq <= 1; go();
        pat(0, 80, 4, 1);
        s.mutingRestartReq <= 0; s.mutingOverride <= 1; go();
        pat(0, 80, 4, 1);
        s.teachError <= 1; go();
        pat(0, 80, 40, 10);
    endtask

    task automatic t_registers();
        wb(0, indicator_pkg::CTRL_OFFSET, 32'h0, q);
        check(q, indicator_pkg::CTRL_RESET, "ctrl reset");
        wb(0, 8'h10, 32'h0, q);
        check(q, 32'h0, "unmapped read");
        // every event kind has happened by now and nothing cleared it
        wb(0, indicator_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
        check(q, 32'h0000_001f, "all events latched");
        s <= '0;
        wb(1, indicator_pkg::CTRL_OFFSET, 32'h0, q);
        go();
        pat(3, 80, 0, 0);
        wb(1, indicator_pkg::CTRL_OFFSET, 32'h1, q);
        wb(1, indicator_pkg::IRQ_STATUS_OFFSET, 32'h1f, q);
        wb(1, indicator_pkg::IRQ_MASK_OFFSET, 32'h1, q);
        wb(0, indicator_pkg::IRQ_MASK_OFFSET, 32'h0, q);
        check(q, 32'h1, "mask readback");
        s.internalFault <= 1; go();
        check(32'(irq), 32'h1, "irq raised");
        wb(0, indicator_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
        check(q & 32'h1, 32'h1, "fault status set");
        wb(1, indicator_pkg::IRQ_MASK_OFFSET, 32'h0, q);
        go();
        check(32'(irq), 32'h0, "irq masked");
        wb(1, indicator_pkg::IRQ_STATUS_OFFSET, 32'h1, q);
        wb(0, indicator_pkg::IRQ_STATUS_OFFSET, 32'h0, q);
        check(q & 32'h1, 32'h0, "status cleared");
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        t_channel();
        t_lamp_one();
        t_lamp_two();
        t_lamp_three();
        t_registers();
        report_and_stop();
    end
endmodule
